// *** hw/pin_irq_defines.svh ***
// Offsets, field positions, reset values and timing counts of the pin interrupt unit.
`ifndef PIN_IRQ_DEFINES_SVH
`define PIN_IRQ_DEFINES_SVH

// Register byte offsets on the bus, decoded from haddr[7:0].
`define OFS_SENSE_PRIMARY  8'h00
`define OFS_SENSE_EXTENDED 8'h04
`define OFS_PIN_IRQ_ENABLE 8'h08
`define OFS_PIN_IRQ_PEND   8'h0c

// Sense field positions in the primary control register.
`define PIN_A_SENSE_LSB    0
`define PIN_B_SENSE_LSB    2
// Edge select bit of pin C in the extended control register.
`define PIN_C_EDGE_BIT     0

// Enable and pending bit positions, shared by both registers.
`define PIN_B_BIT          7
`define PIN_A_BIT          6
`define PIN_C_BIT          5

// Reset value of every register of the unit.
`define REG_RESET          8'h00

// Watchdog oscillator period and system clock period, in ns.
`define WDT_PERIOD_NS      1000
`define CLK_PERIOD_NS      20
// Cycles of hclk per watchdog tick, rounded down.
`define WDT_CYCLES         (`WDT_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// *** hw/pin_irq_pkg.sv ***
// Types shared by the pin interrupt unit and its sense channels.
package pin_irq_pkg;

  // Sense modes of pins A and B, in field order.
  typedef enum logic [1:0] {
    SENSE_LOW,
    SENSE_CHANGE,
    SENSE_FALL,
    SENSE_RISE
  } sense_mode_t;

  // Steps of the power-down level wake sampler.
  typedef enum logic [1:0] {
    WAKE_IDLE,
    WAKE_FIRST,
    WAKE_HELD
  } wake_state_t;

  // State of one sense channel.
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
  } chan_state_t;

  // State of the whole unit.
  typedef struct packed {
    logic [7:0]  sense_pri;
    logic [7:0]  sense_ext;
    logic [7:0]  enable;
    logic [2:0]  pend;
    logic        c_prev;
    logic        dsel;
    logic        dwrite;
    logic [7:0]  daddr;
    logic [31:0] rdata;
    logic [5:0]  wdt_cnt;
    wake_state_t wake;
  } unit_state_t;

endpackage

// *** hw/sense_chan_if.sv ***
// Link between the unit and one synchronous sense channel.
`timescale 1ns/10ps
interface sense_chan_if;
  logic       pin;        // Pad level of the pin.
  logic       io_en;      // High while the I/O clock runs.
  logic [1:0] mode;       // Sense mode field.
  logic       event_hit;  // One-cycle edge or change event.
  logic       level_req;  // Low-level request, follows the pin.
  modport ctrl (output pin, io_en, mode, input event_hit, level_req);
  modport chan (input pin, io_en, mode, output event_hit, level_req);
endinterface

// *** hw/pin_sense_channel.sv ***
// Synchronous sense channel for one level or edge sensed pin.
`timescale 1ns/10ps
module pin_sense_channel (
  // Clock and reset.
  input wire logic     hclk,
  input wire logic     hresetn,
  // Link to the unit.
  sense_chan_if.chan   sc
);

  pin_irq_pkg::chan_state_t st;   // Registered channel state.
  pin_irq_pkg::chan_state_t nxt;  // Next channel state.
  pin_irq_pkg::sense_mode_t mode; // Mode field as an enum.

  assign mode = pin_irq_pkg::sense_mode_t'(sc.mode);

  // The pipe only moves while the I/O clock runs, like the real gated clock.
  always_comb begin
    nxt = st;
    if (sc.io_en) begin
      nxt.sync1 = sc.pin;
      nxt.sync2 = st.sync1;
      nxt.prev  = st.sync2;
    end
  end

  // Edge events compare the synchronised sample with the previous one.
  always_comb begin
    sc.event_hit = 1'b0;
    if (sc.io_en) begin
      case (mode)
        pin_irq_pkg::SENSE_CHANGE: sc.event_hit = st.sync2 ^ st.prev;
        pin_irq_pkg::SENSE_FALL:   sc.event_hit = st.prev & ~st.sync2;
        pin_irq_pkg::SENSE_RISE:   sc.event_hit = ~st.prev & st.sync2;
        default:                   sc.event_hit = 1'b0;
      endcase
    end
  end

  // Low level is taken straight from the pad, so it needs no clock and drops at once.
  assign sc.level_req = (mode == pin_irq_pkg::SENSE_LOW) & ~sc.pin;

  // Reset to high so a quiet high pin raises nothing after reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1};
    end else begin
      st <= nxt;
    end
  end

  // A pin held high then low, with the clock running, shows a fall event.
  sequence s_fall_seen;
    (sc.io_en && sc.mode == 2'h2 && sc.pin)[*3] ##1 (sc.io_en && sc.mode == 2'h2 && !sc.pin)[*3];
  endsequence
  a_fall_event: assert property (@(posedge hclk) disable iff (!hresetn)
    s_fall_seen |-> sc.event_hit) else $error("Fall on pin gave no event.");

  a_edge_needs_clk: assert property (@(posedge hclk) disable iff (!hresetn)
    !sc.io_en |-> !sc.event_hit) else $error("Edge event with I/O clock stopped.");

  a_low_level_req: assert property (@(posedge hclk) disable iff (!hresetn)
    (sc.mode == 2'h0 && !sc.pin) |-> sc.level_req) else $error("Low pin raised no request.");

endmodule // pin_sense_channel

// *** hw/external_pin_interrupt_unit.sv ***
// Pin interrupt unit: sense control, enables, pending flags and wake logic on AHB-Lite.
//
// Behaviour
// - Pins detected even when driven as outputs.
// - Low-level mode requests while pin stays low.
// - Edge modes on A, B need I/O clock.
// - Low level and pin C work clockless.
// - Power-down level wake needs two watchdog samples.
// - Pin B sense field at bits 3:2.
// - Pin A sense field at bits 1:0.
// - Pins sampled; pulses over one clock detected.
// - Pin C bit selects falling or rising edge.
// - Request needs own enable and global enable.
// - Each pin has its own request vector.
// - Edge events set pending flags 7, 6, 5.
// - Flags clear on entry or writing one.
// - Level mode flag always reads cleared.
// - Deep sleep without enable may set pin C.
//
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`include "pin_irq_defines.svh"
module external_pin_interrupt_unit (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Interrupt pins, pad levels.
  input  wire logic        irq_pin_a,
  input  wire logic        irq_pin_b,
  input  wire logic        irq_pin_c,
  // Core and power manager.
  input  wire logic        global_irq_en,
  input  wire logic [2:0]  irq_ack,
  input  wire logic        io_clk_run,
  input  wire logic        deep_sleep,
  input  wire logic        power_down,
  // Requests to the core, one per vector: 0 pin A, 1 pin B, 2 pin C.
  output logic      [2:0]  irq_req,
  output logic             wake_req
);

  localparam logic [5:0] WDT_LAST = 6'(`WDT_CYCLES - 1);  // Last count of a tick.

  pin_irq_pkg::unit_state_t st;   // Registered state.
  pin_irq_pkg::unit_state_t nxt;  // Next state.

  logic [1:0] ab_event;           // Edge events from channels A and B.
  logic [1:0] ab_level;           // Level requests from channels A and B.
  logic [1:0] ab_pins;            // Pad levels of pins A and B.
  logic [1:0] ab_low_mode;        // Channel is in low-level mode.
  logic [2:0] en_bits;            // Enable bits in pin order A, B, C.
  logic       pin_c_int;          // Pin C behind its input buffer.
  logic       c_lvl;              // Pin C level in the selected polarity.
  logic       c_event;            // Pin C edge event.
  logic       take;               // Address phase accepted.
  logic       wr;                 // Register write data phase.
  logic       wdt_tick;           // Watchdog oscillator tick enable.
  logic       lvl_wake;           // Enabled level source is low.
  logic [2:0] clr;                // Flag clears in pin order.
  logic [2:0] set;                // Flag sets in pin order.

  // The pad level includes whatever the port itself drives, so output pins still trigger.
  assign ab_pins = {irq_pin_b, irq_pin_a};

  sense_chan_if sc [2] ();

  // One synchronous sense channel per level and edge sensed pin.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_chan
      assign sc[g].pin   = ab_pins[g];
      assign sc[g].io_en = io_clk_run;
      assign sc[g].mode  = st.sense_pri[`PIN_A_SENSE_LSB + 2 * g +: 2];
      assign ab_event[g] = sc[g].event_hit;
      assign ab_level[g] = sc[g].level_req;
      assign ab_low_mode[g] = (sc[g].mode == 2'h0);
      pin_sense_channel u_chan (
        .hclk    (hclk),
        .hresetn (hresetn),
        .sc      (sc[g])
      );
    end
  endgenerate

  assign en_bits = {st.enable[`PIN_C_BIT], st.enable[`PIN_B_BIT], st.enable[`PIN_A_BIT]};

  // Without its enable, deep sleep turns the pin C buffer off and the internal level drops low.
  assign pin_c_int = irq_pin_c & ~(deep_sleep & ~en_bits[2]);

  // Pin C runs every hclk, independent of the I/O clock; polarity flip can itself fire.
  assign c_lvl   = ~(pin_c_int ^ st.sense_ext[`PIN_C_EDGE_BIT]);
  assign c_event = c_lvl & ~st.c_prev;

  // Bus decode: the slave always answers at once with OKAY.
  assign take      = hsel & hready & htrans[1];
  assign wr        = st.dsel & st.dwrite;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st.rdata;

  // Watchdog tick divider, one enable pulse each watchdog period.
  assign wdt_tick = (st.wdt_cnt == WDT_LAST);

  // A low enabled level source counts toward wake-up.
  assign lvl_wake = |(ab_level & en_bits[1:0]);

  // Flag sets and clears; a set in the same cycle as a clear wins.
  always_comb begin
    set = {c_event, ab_event};
    clr = irq_ack;
    if (wr && st.daddr == `OFS_PIN_IRQ_PEND) begin
      clr[0] = clr[0] | hwdata[`PIN_A_BIT];
      clr[1] = clr[1] | hwdata[`PIN_B_BIT];
      clr[2] = clr[2] | hwdata[`PIN_C_BIT];
    end
  end

  // Next state of the whole unit.
  always_comb begin
    nxt = st;
    // Data phase of a write stores the low byte.
    if (wr) begin
      if (st.daddr == `OFS_SENSE_PRIMARY) begin
        nxt.sense_pri = hwdata[7:0];
      end else if (st.daddr == `OFS_SENSE_EXTENDED) begin
        nxt.sense_ext = hwdata[7:0];
      end else if (st.daddr == `OFS_PIN_IRQ_ENABLE) begin
        nxt.enable = hwdata[7:0];
      end
    end
    // Pending flags.
    for (int i = 0; i < 3; i++) begin
      nxt.pend[i] = set[i] | (st.pend[i] & ~clr[i]);
    end
    // Level mode owns no flag, so it is held clear.
    for (int i = 0; i < 2; i++) begin
      if (nxt.sense_pri[`PIN_A_SENSE_LSB + 2 * i +: 2] == 2'h0) begin
        nxt.pend[i] = 1'b0;
      end
    end
    nxt.c_prev = c_lvl;
    // Address phase, read data built from the updated registers so back to back is coherent.
    nxt.dsel = take;
    if (take) begin
      nxt.dwrite = hwrite;
      nxt.daddr  = haddr[7:0];
      nxt.rdata  = 32'h0000_0000;
      if (haddr[7:0] == `OFS_SENSE_PRIMARY) begin
        nxt.rdata[7:0] = nxt.sense_pri;
      end else if (haddr[7:0] == `OFS_SENSE_EXTENDED) begin
        nxt.rdata[7:0] = nxt.sense_ext;
      end else if (haddr[7:0] == `OFS_PIN_IRQ_ENABLE) begin
        nxt.rdata[7:0] = nxt.enable;
      end else if (haddr[7:0] == `OFS_PIN_IRQ_PEND) begin
        nxt.rdata[`PIN_A_BIT] = nxt.pend[0];
        nxt.rdata[`PIN_B_BIT] = nxt.pend[1];
        nxt.rdata[`PIN_C_BIT] = nxt.pend[2];
      end
    end
    // Watchdog divider.
    nxt.wdt_cnt = wdt_tick ? 6'h00 : st.wdt_cnt + 6'h01;
    // Level wake sampler, only meaningful in power-down.
    case (st.wake)
      pin_irq_pkg::WAKE_IDLE: begin
        if (power_down && wdt_tick && lvl_wake) begin
          nxt.wake = pin_irq_pkg::WAKE_FIRST;
        end
      end
      pin_irq_pkg::WAKE_FIRST: begin
        if (!power_down || !lvl_wake) begin
          nxt.wake = pin_irq_pkg::WAKE_IDLE;
        end else if (wdt_tick) begin
          nxt.wake = pin_irq_pkg::WAKE_HELD;
        end
      end
      pin_irq_pkg::WAKE_HELD: begin
        // Held until power-down ends; a level lost meanwhile wakes without a request.
        if (!power_down) begin
          nxt.wake = pin_irq_pkg::WAKE_IDLE;
        end
      end
      default: begin
        nxt.wake = pin_irq_pkg::WAKE_IDLE;
      end
    endcase
  end

  // Requests per vector; level requests bypass the flags and follow the pin.
  always_comb begin
    irq_req[0] = global_irq_en & en_bits[0] & (st.pend[0] | ab_level[0]);
    irq_req[1] = global_irq_en & en_bits[1] & (st.pend[1] | ab_level[1]);
    irq_req[2] = global_irq_en & en_bits[2] & st.pend[2];
  end

  // Pin C edges wake from any sleep; levels only after the watchdog samples.
  assign wake_req = (st.wake == pin_irq_pkg::WAKE_HELD) | (st.pend[2] & en_bits[2]);

  // The single state register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '{sense_pri: `REG_RESET, sense_ext: `REG_RESET, enable: `REG_RESET,
              pend: 3'h0, c_prev: 1'b1, dsel: 1'b0, dwrite: 1'b0, daddr: 8'h00,
              rdata: 32'h0000_0000, wdt_cnt: 6'h00, wake: pin_irq_pkg::WAKE_IDLE};
    end else begin
      st <= nxt;
    end
  end

  // Rising edge on pin C with rising select sets its flag next cycle.
  sequence s_c_rise;
    (st.sense_ext[0] && !deep_sleep && !irq_pin_c) ##1 (st.sense_ext[0] && !deep_sleep && irq_pin_c);
  endsequence
  a_c_rise_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    s_c_rise |=> st.pend[2]) else $error("Pin C rise did not set its flag.");

  a_set_wins_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (c_event && irq_ack[2]) |=> st.pend[2]) else $error("Clear beat a pin C event.");

  a_ack_clears_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    (irq_ack[2] && !c_event) |=> !st.pend[2]) else $error("Ack did not clear pin C flag.");

  a_level_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (st.sense_pri[3:2] == 2'h0) |-> !st.pend[1]) else $error("Level mode flag set.");

  a_req_needs_gie: assert property (@(posedge hclk) disable iff (!hresetn)
    !global_irq_en |-> irq_req == 3'h0) else $error("Request without global enable.");

  // Level wake needs two ticks of the watchdog divider while in power-down.
  a_wake_two_ticks: assert property (@(posedge hclk) disable iff (!hresetn)
    (st.wake == pin_irq_pkg::WAKE_IDLE) ##1 (st.wake == pin_irq_pkg::WAKE_FIRST)
      |-> (st.wake != pin_irq_pkg::WAKE_HELD)[*8]) else $error("Level wake too early.");

endmodule // external_pin_interrupt_unit

// *** dv/pin_source_model.sv ***
// Behavioural model of the external sources that drive the three interrupt pins.
`timescale 1ns/10ps
module pin_source_model (
  // Clock.
  input wire logic hclk,
  // Pad levels towards the unit.
  output logic     pin_a,
  output logic     pin_b,
  output logic     pin_c
);
  // Shortest time a level stands, in cycles: 60 ns, so no pulse is ever too short to count.
  localparam int MIN_CYC = 3;

  // Idle sources leave the pins high.
  initial begin
    pin_a = 1'b1;
    pin_b = 1'b1;
    pin_c = 1'b1;
  end

  // Drives {c, b, a} after an edge and holds it until the level is surely seen.
  task automatic set_pins(input logic [2:0] lvl);
    pin_a <= lvl[0];
    pin_b <= lvl[1];
    pin_c <= lvl[2];
    repeat (MIN_CYC) @(posedge hclk);
  endtask
endmodule // pin_source_model

// *** dv/external_pin_interrupt_unit_test.sv ***
// Self-checking testbench of the pin interrupt unit.
`timescale 1ns/10ps
module external_pin_interrupt_unit_test;
  // Bus signals.
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hready, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  // Pins, core and power manager.
  logic        irq_pin_a, irq_pin_b, irq_pin_c;
  logic        global_irq_en, io_clk_run, deep_sleep, power_down, wake_req;
  logic [2:0]  irq_ack, irq_req;
  // Bench bookkeeping.
  logic [7:0]  bit_v;
  int          err_count = 0;
  int          total_checks = 0;
  int          cyc = 0;

  // The single slave's ready is the bus ready.
  logic        hreadyout;
  assign hready = hreadyout;

  // A 50 MHz clock.
  always #10 hclk = ~hclk;

  pin_source_model src (.hclk, .pin_a(irq_pin_a), .pin_b(irq_pin_b), .pin_c(irq_pin_c));

  external_pin_interrupt_unit dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready, .hwdata, .hrdata, .hreadyout, .hresp, .irq_pin_a, .irq_pin_b, .irq_pin_c,
    .global_irq_en, .irq_ack, .io_clk_run, .deep_sleep, .power_down, .irq_req, .wake_req);

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("Checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // A hang is cut short far beyond the few hundred cycles the run needs.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  // Compares one value and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One single word transfer; read data are taken at the data phase's edge.
  task automatic xfer(input logic wr_n, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr_n;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    // Upper data bits are set so that a decode of more than the low byte shows up.
    hwdata <= {24'ha5a5a5, d};
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  // Register write.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  // Register read compared with a byte; the upper bits must read zero.
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk(q, {24'h0, exp});
    chk({31'h0, hresp}, 32'h0);
  endtask

  // One-cycle vector entry pulse from the core.
  task automatic ack(input logic [2:0] m);
    irq_ack <= m;
    @(posedge hclk);
    irq_ack <= 3'h0;
    @(posedge hclk);
  endtask

  // Main sequence.
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    global_irq_en = 1'b1;
    irq_ack = 3'h0;
    io_clk_run = 1'b1;
    deep_sleep = 1'b0;
    power_down = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, read-back and an unmapped place.
    for (int a = 0; a < 20; a += 4) begin
      rdchk(8'(a), 8'h00);
    end
    wr(8'h00, 8'h5a);
    rdchk(8'h00, 8'h5a);
    wr(8'h04, 8'ha4);
    rdchk(8'h04, 8'ha4);
    wr(8'h08, 8'he0);
    rdchk(8'h08, 8'he0);
    wr(8'h08, 8'h00);
    wr(8'h10, 8'hff);
    rdchk(8'h10, 8'h00);
    // Every edge mode of pins A and B: fall, then rise.
    for (int p = 0; p < 2; p++) begin
      for (int m = 1; m < 4; m++) begin
        bit_v = (p == 0) ? 8'h40 : 8'h80;
        wr(8'h00, 8'(m << (2 * p)));
        wr(8'h08, bit_v);
        wr(8'h0c, 8'he0);
        src.set_pins((p == 0) ? 3'b110 : 3'b101);
        repeat (4) @(posedge hclk);
        rdchk(8'h0c, (m != 3) ? bit_v : 8'h00);
        chk({31'h0, irq_req[p]}, {31'h0, m != 3});
        ack((p == 0) ? 3'b001 : 3'b010);
        rdchk(8'h0c, 8'h00);
        src.set_pins(3'b111);
        repeat (4) @(posedge hclk);
        rdchk(8'h0c, (m != 2) ? bit_v : 8'h00);
        wr(8'h0c, bit_v);
        rdchk(8'h0c, 8'h00);
      end
    end
    // Low level with the I/O clock stopped; edges must then go unseen.
    wr(8'h00, 8'h00);
    wr(8'h08, 8'h40);
    io_clk_run <= 1'b0;
    src.set_pins(3'b110);
    chk({31'h0, irq_req[0]}, 32'h1);
    rdchk(8'h0c, 8'h00);
    global_irq_en <= 1'b0;
    @(posedge hclk);
    chk({31'h0, irq_req[0]}, 32'h0);
    global_irq_en <= 1'b1;
    src.set_pins(3'b111);
    chk({31'h0, irq_req[0]}, 32'h0);
    wr(8'h00, 8'h02);
    src.set_pins(3'b110);
    repeat (4) @(posedge hclk);
    rdchk(8'h0c, 8'h00);
    src.set_pins(3'b111);
    io_clk_run <= 1'b1;
    wr(8'h0c, 8'he0);
    // Pin C falling, then the safe change of its edge select, then rising.
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h20);
    src.set_pins(3'b011);
    rdchk(8'h0c, 8'h20);
    chk({29'h0, irq_req}, 32'h4);
    ack(3'b100);
    rdchk(8'h0c, 8'h00);
    wr(8'h08, 8'h00);
    wr(8'h04, 8'h01);
    wr(8'h0c, 8'h20);
    wr(8'h08, 8'h20);
    rdchk(8'h0c, 8'h00);
    src.set_pins(3'b111);
    rdchk(8'h0c, 8'h20);
    wr(8'h08, 8'h00);
    deep_sleep <= 1'b1;
    @(posedge hclk);
    deep_sleep <= 1'b0;
    rdchk(8'h0c, 8'h20);
    wr(8'h0c, 8'he0);
    // Power-down wake needs two watchdog samples of the low level.
    wr(8'h00, 8'h00);
    wr(8'h08, 8'h40);
    power_down <= 1'b1;
    src.set_pins(3'b110);
    chk({31'h0, wake_req}, 32'h0);
    for (int i = 0; i < 200 && wake_req !== 1'b1; i++) begin
      @(posedge hclk);
    end
    chk({31'h0, wake_req}, 32'h1);
    power_down <= 1'b0;
    src.set_pins(3'b111);
    chk({31'h0, wake_req}, 32'h0);
    end_sim();
  end
endmodule // external_pin_interrupt_unit_test
